// ---- bench/mie_testbench.sv ----
// Self-checking bench for the miscellaneous instruction execute block
`timescale 1ns/10ps
`default_nettype none
`include "mie_defines.svh"

module testbench;
   import mie_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic instr_valid, skip_next, acc_we, wd_set, done_set, wake_pin;
   logic [9:0] instr_code;
   logic [3:0] acc_in, acc_out;
   mie_pwr_t pwr_state;
   logic wd_stop_en, wd_flag, done_flag, adc_start, cmp_start, irq;
   int err_count, comparisons;

   mie_misc_exec mie_misc_exec_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .instr_valid(instr_valid), .instr_code(instr_code), .acc_in(acc_in), .skip_next(skip_next),
      .acc_out(acc_out), .acc_we(acc_we), .watchdog_flag_set(wd_set), .conversion_done_set(done_set),
      .wake_pin(wake_pin), .pwr_state(pwr_state), .watchdog_stop_enable(wd_stop_en),
      .watchdog_flag_one(wd_flag), .conversion_done_flag(done_flag), .adc_start(adc_start),
      .cmp_start(cmp_start), .irq(irq));

   ////////////////////////////////////////////////////////////////
   // Shared tasks
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask

   // One APB transfer; holds the request until pready is sampled high at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      // A wait that runs out counts as a mismatch
      chk("apb ready", {31'h0, pready}, 32'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // One instruction; outputs are looked at just after the edge that takes it
   task automatic exec(input logic [9:0] c, input logic [3:0] a);
      @(posedge pclk);
      instr_valid <= 1'b1;
      instr_code <= c;
      acc_in <= a;
      @(posedge pclk);
      instr_valid <= 1'b0;
      #1;
   endtask

   // One-cycle flag set pulse: sel 0 watchdog, 1 converter done
   task automatic pulse(input logic sel);
      @(posedge pclk);
      if (sel) done_set <= 1'b1;
      else wd_set <= 1'b1;
      @(posedge pclk);
      done_set <= 1'b0;
      wd_set <= 1'b0;
      #1;
   endtask

   ////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_regs;
      chk("pwr reset", {29'h0, pwr_state}, {29'h0, MIE_PWR_RUN});
      apb(1'b0, `MIE_ADDR_CTRL, 32'h0);
      chk("ctrl reset", rd, 32'h0);
      apb(1'b0, `MIE_ADDR_IRQ_MASK, 32'h0);
      chk("mask reset", rd, 32'h0);
      apb(1'b1, `MIE_ADDR_CTRL, 32'hFFFFFFFF);
      apb(1'b0, `MIE_ADDR_CTRL, 32'h0);
      chk("ctrl rw", rd, 32'h1F);
      apb(1'b1, `MIE_ADDR_STATUS, 32'h7);
      apb(1'b0, `MIE_ADDR_STATUS, 32'h0);
      chk("status ro", rd, 32'h0);
      apb(1'b0, 8'h10, 32'h0);
      chk("unmapped err", {31'h0, err}, 32'h1);
      $display("test regs done");
   endtask

   task automatic t_addi;
      logic [3:0] av[4] = '{4'h5, 4'h8, 4'h0, 4'hF};
      logic [3:0] nv[4] = '{4'hA, 4'h8, 4'h0, 4'hF};
      logic [4:0] s;
      for (int i = 0; i < 4; i++) begin
         s = {1'b0, av[i]} + {1'b0, nv[i]};
         exec({`MIE_OP_ADDI_HI, nv[i]}, av[i]);
         chk("addi we", {31'h0, acc_we}, 32'h1);
         chk("addi sum", {28'h0, acc_out}, {28'h0, s[3:0]});
         chk("addi skip", {31'h0, skip_next}, {31'h0, ~s[4]});
      end
      $display("test addi done");
   endtask

   task automatic t_wdog;
      pulse(1'b0);
      chk("wd flag set", {31'h0, wd_flag}, 32'h1);
      exec(`MIE_OP_WD_TEST, 4'h0);
      chk("wtest skip", {31'h0, skip_next}, 32'h1);
      chk("wtest clear", {31'h0, wd_flag}, 32'h0);
      exec(`MIE_OP_WD_TEST, 4'h0);
      chk("wtest noskip", {31'h0, skip_next}, 32'h0);
      exec(`MIE_OP_WD_STOP, 4'h0);
      chk("stop enable", {31'h0, wd_stop_en}, 32'h1);
      pulse(1'b0);
      apb(1'b0, `MIE_ADDR_STATUS, 32'h0);
      chk("status", rd, 32'h5);
      // Test instruction and a new flag set at one edge: skip, and the set wins
      @(posedge pclk);
      instr_valid <= 1'b1;
      instr_code <= `MIE_OP_WD_TEST;
      wd_set <= 1'b1;
      @(posedge pclk);
      instr_valid <= 1'b0;
      wd_set <= 1'b0;
      #1;
      chk("wtest set wins", {30'h0, skip_next, wd_flag}, 32'h3);
      $display("test watchdog done");
   endtask

   task automatic t_conv;
      apb(1'b1, `MIE_ADDR_CTRL, 32'h0);
      pulse(1'b1);
      exec(`MIE_OP_CONV_START, 4'h0);
      chk("adc start", {30'h0, adc_start, cmp_start}, 32'h2);
      chk("done clear", {31'h0, done_flag}, 32'h0);
      apb(1'b1, `MIE_ADDR_CTRL, 32'h8);
      exec(`MIE_OP_CONV_START, 4'h0);
      chk("cmp start", {30'h0, adc_start, cmp_start}, 32'h1);
      pulse(1'b1);
      exec(`MIE_OP_CONV_SKIP, 4'h0);
      chk("dskip skip", {30'h0, skip_next, done_flag}, 32'h2);
      exec(`MIE_OP_CONV_SKIP, 4'h0);
      chk("dskip none", {31'h0, skip_next}, 32'h0);
      apb(1'b1, `MIE_ADDR_CTRL, 32'h10);
      pulse(1'b1);
      exec(`MIE_OP_CONV_SKIP, 4'h0);
      chk("dskip nop", {30'h0, skip_next, done_flag}, 32'h1);
      $display("test converter done");
   endtask

   task automatic t_irq;
      apb(1'b1, `MIE_ADDR_IRQ_MASK, 32'h0);
      apb(1'b0, `MIE_ADDR_IRQ_STAT, 32'h0);
      apb(1'b1, `MIE_ADDR_CTRL, 32'h0);
      exec(`MIE_OP_CONV_START, 4'h0);
      repeat (2) @(posedge pclk);
      #1;
      chk("irq masked", {31'h0, irq}, 32'h0);
      apb(1'b1, `MIE_ADDR_IRQ_MASK, 32'h2);
      #1;
      chk("irq raised", {31'h0, irq}, 32'h1);
      apb(1'b0, `MIE_ADDR_IRQ_STAT, 32'h0);
      chk("irq stat", rd, 32'h2);
      repeat (2) @(posedge pclk);
      #1;
      chk("irq cleared", {31'h0, irq}, 32'h0);
      $display("test irq done");
   endtask

   task automatic t_pwr;
      int i;
      exec(`MIE_OP_POWER_OFF, 4'h0);
      chk("poweroff unarmed", {29'h0, pwr_state}, {29'h0, MIE_PWR_RUN});
      exec(`MIE_OP_POWER_EN, 4'h0);
      chk("armed", {29'h0, pwr_state}, {29'h0, MIE_PWR_ARMED});
      exec({`MIE_OP_ADDI_HI, 4'h1}, 4'h0);
      exec(`MIE_OP_POWER_OFF, 4'h0);
      chk("poweroff disarmed", {29'h0, pwr_state}, {29'h0, MIE_PWR_RUN});
      exec(`MIE_OP_POWER_EN, 4'h0);
      exec(`MIE_OP_POWER_EN, 4'h0);
      chk("armed twice", {29'h0, pwr_state}, {29'h0, MIE_PWR_ARMED});
      exec(`MIE_OP_POWER_OFF, 4'h0);
      chk("backup", {29'h0, pwr_state}, {29'h0, MIE_PWR_BACKUP});
      exec({`MIE_OP_ADDI_HI, 4'h1}, 4'h0);
      chk("backup idle", {31'h0, acc_we}, 32'h0);
      @(posedge pclk);
      wake_pin <= 1'b1;
      for (i = 0; i < 10 && pwr_state !== MIE_PWR_RUN; i++) begin
         @(posedge pclk);
         #1;
      end
      chk("wake", {29'h0, pwr_state}, {29'h0, MIE_PWR_RUN});
      @(posedge pclk);
      wake_pin <= 1'b0;
      $display("test power done");
   endtask

   ////////////////////////////////////////////////////////////////
   // Verdict and run control
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // Clock
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   // Main sequence
   initial begin
      {presetn, psel, penable, pwrite, instr_valid, wd_set, done_set, wake_pin} = 8'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      instr_code = 10'h000;
      acc_in = 4'h0;
      err_count = 0;
      comparisons = 0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      #1;
      t_regs();
      t_addi();
      t_wdog();
      t_conv();
      t_irq();
      t_pwr();
      wrap_up();
   end

   // Hang guard, some thirty times the expected run length
   initial begin
      #100000;
      err_count++;
      wrap_up();
   end
endmodule
`default_nettype wire

// ---- core/mie_defines.svh ----
// Constants of the miscellaneous instruction execute block
`ifndef MIE_DEFINES_SVH
`define MIE_DEFINES_SVH

// Instruction codes (10-bit instruction word)
`define MIE_OP_ADDI_HI 6'h06
`define MIE_OP_CONV_START 10'h29F
`define MIE_OP_POWER_OFF 10'h002
`define MIE_OP_POWER_EN 10'h05B
`define MIE_OP_WD_STOP 10'h29C
`define MIE_OP_WD_TEST 10'h2A0
`define MIE_OP_CONV_SKIP 10'h287

// APB register byte offsets
`define MIE_ADDR_CTRL 8'h00
`define MIE_ADDR_STATUS 8'h04
`define MIE_ADDR_IRQ_STAT 8'h08
`define MIE_ADDR_IRQ_MASK 8'h0C

// Field positions
`define MIE_CTRL_IRQEN_BIT 4
`define MIE_CTRL_MODE_BIT 3
`define MIE_ST_WDFLAG_BIT 0
`define MIE_ST_DONE_BIT 1
`define MIE_ST_STOPEN_BIT 2

// Event bits of the interrupt status register
`define MIE_EV_BACKUP 0
`define MIE_EV_CONV_START 1
`define MIE_EV_CONV_DONE 2
`define MIE_EV_WDFLAG 3

// Reset values
`define MIE_RST_CTRL 4'h0
`define MIE_RST_MASK 4'h0

`endif

// ---- core/mie_misc_exec.sv ----
// Execute logic for power-down, watchdog, add-immediate and converter-start instructions
`timescale 1ns/10ps
`default_nettype none
`include "mie_defines.svh"

module mie_misc_exec #(
   parameter logic [9:0] OP_POWER_OFF = `MIE_OP_POWER_OFF,
   parameter logic [9:0] OP_POWER_EN = `MIE_OP_POWER_EN,
   parameter logic [9:0] OP_WD_STOP = `MIE_OP_WD_STOP,
   parameter logic [9:0] OP_WD_TEST = `MIE_OP_WD_TEST,
   parameter logic [9:0] OP_CONV_START = `MIE_OP_CONV_START,
   parameter logic [9:0] OP_CONV_SKIP = `MIE_OP_CONV_SKIP
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Instruction stream from the core
   input wire logic instr_valid,
   input wire logic [9:0] instr_code,
   input wire logic [3:0] acc_in,
   // Answers to the core
   output logic skip_next,
   output logic [3:0] acc_out,
   output logic acc_we,
   // Flag set events from watchdog and converter
   input wire logic watchdog_flag_set,
   input wire logic conversion_done_set,
   // Wakeup pin, asynchronous
   input wire logic wake_pin,
   // Control outputs
   output mie_pkg::mie_pwr_t pwr_state,
   output logic watchdog_stop_enable,
   output logic watchdog_flag_one,
   output logic conversion_done_flag,
   output logic adc_start,
   output logic cmp_start,
   output logic irq
);
   import mie_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Decode

   mie_op_t op;
   logic [3:0] imm;
   logic exec_ok;
   logic [4:0] addi_sum;
   mie_state_t s_r;
   mie_state_t s_nxt;

   mie_op_decode #(
      .OP_POWER_OFF(OP_POWER_OFF),
      .OP_POWER_EN(OP_POWER_EN),
      .OP_WD_STOP(OP_WD_STOP),
      .OP_WD_TEST(OP_WD_TEST),
      .OP_CONV_START(OP_CONV_START),
      .OP_CONV_SKIP(OP_CONV_SKIP)
   ) u_dec (
      .instr_code(instr_code),
      .op(op),
      .imm(imm)
   );

   // Instructions are ignored while in backup mode
   assign exec_ok = instr_valid && (s_r.pwr != MIE_PWR_BACKUP);
   assign addi_sum = {1'b0, acc_in} + {1'b0, imm};

   // Is the address one of the four registers
   function automatic logic reg_hit(input logic [7:0] a);
      return (a == `MIE_ADDR_CTRL) || (a == `MIE_ADDR_STATUS) ||
             (a == `MIE_ADDR_IRQ_STAT) || (a == `MIE_ADDR_IRQ_MASK);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      logic [3:0] ev;
      ev = 4'h0;
      s_nxt = s_r;
      s_nxt.skip = 1'b0;
      s_nxt.acc_we = 1'b0;
      s_nxt.adc_start = 1'b0;
      s_nxt.cmp_start = 1'b0;
      s_nxt.pready = 1'b0;
      s_nxt.pslverr = 1'b0;
      // Wakeup pin synchroniser
      s_nxt.wake_s1 = wake_pin;
      s_nxt.wake_s2 = s_r.wake_s1;

      // Power state: arming lasts until the next instruction other than a power enable
      case (s_r.pwr)
         MIE_PWR_RUN: begin
            if (exec_ok && op == MIE_OP_POWER_EN) begin
               s_nxt.pwr = MIE_PWR_ARMED;
            end
         end
         MIE_PWR_ARMED: begin
            if (exec_ok && op == MIE_OP_POWER_OFF) begin
               s_nxt.pwr = MIE_PWR_BACKUP;
               ev[`MIE_EV_BACKUP] = 1'b1;
            end else if (exec_ok && op != MIE_OP_POWER_EN) begin
               s_nxt.pwr = MIE_PWR_RUN;
            end
         end
         MIE_PWR_BACKUP: begin
            if (s_r.wake_s2) begin
               s_nxt.pwr = MIE_PWR_RUN;
            end
         end
         default: begin
            s_nxt.pwr = MIE_PWR_RUN;
         end
      endcase

      // Instruction execution
      if (exec_ok) begin
         case (op)
            MIE_OP_ADDI: begin
               s_nxt.acc = addi_sum[3:0];
               s_nxt.acc_we = 1'b1;
               s_nxt.skip = ~addi_sum[4];
            end
            MIE_OP_WD_STOP: begin
               s_nxt.watchdog_stop_enable = 1'b1;
            end
            MIE_OP_WD_TEST: begin
               if (s_r.watchdog_flag_one) begin
                  s_nxt.skip = 1'b1;
                  s_nxt.watchdog_flag_one = 1'b0;
               end
            end
            MIE_OP_CONV_START: begin
               s_nxt.conversion_done_flag = 1'b0;
               ev[`MIE_EV_CONV_START] = 1'b1;
               if (s_r.converter_control_reg[`MIE_CTRL_MODE_BIT]) begin
                  s_nxt.cmp_start = 1'b1;
               end else begin
                  s_nxt.adc_start = 1'b1;
               end
            end
            MIE_OP_CONV_SKIP: begin
               if (!s_r.converter_irq_enable_bit && s_r.conversion_done_flag) begin
                  s_nxt.skip = 1'b1;
                  s_nxt.conversion_done_flag = 1'b0;
               end
            end
            default: begin
            end
         endcase
      end

      // Hardware sets win over instruction clears
      if (watchdog_flag_set) begin
         s_nxt.watchdog_flag_one = 1'b1;
         ev[`MIE_EV_WDFLAG] = 1'b1;
      end
      if (conversion_done_set) begin
         s_nxt.conversion_done_flag = 1'b1;
         ev[`MIE_EV_CONV_DONE] = 1'b1;
      end

      // APB setup: answer in the following access cycle
      if (psel && !penable) begin
         s_nxt.pready = 1'b1;
         s_nxt.pslverr = !reg_hit(paddr);
         s_nxt.prdata = 32'h0000_0000;
         if (!pwrite) begin
            case (paddr)
               `MIE_ADDR_CTRL: begin
                  s_nxt.prdata[3:0] = s_r.converter_control_reg;
                  s_nxt.prdata[`MIE_CTRL_IRQEN_BIT] = s_r.converter_irq_enable_bit;
               end
               `MIE_ADDR_STATUS: begin
                  s_nxt.prdata[`MIE_ST_WDFLAG_BIT] = s_r.watchdog_flag_one;
                  s_nxt.prdata[`MIE_ST_DONE_BIT] = s_r.conversion_done_flag;
                  s_nxt.prdata[`MIE_ST_STOPEN_BIT] = s_r.watchdog_stop_enable;
               end
               `MIE_ADDR_IRQ_STAT: begin
                  s_nxt.prdata[3:0] = s_r.irq_stat;
               end
               `MIE_ADDR_IRQ_MASK: begin
                  s_nxt.prdata[3:0] = s_r.irq_mask;
               end
               default: begin
               end
            endcase
         end
      end

      // APB access completion: writes and read-clear
      if (psel && penable && s_r.pready && reg_hit(paddr)) begin
         if (pwrite) begin
            if (paddr == `MIE_ADDR_CTRL) begin
               s_nxt.converter_control_reg = pwdata[3:0];
               s_nxt.converter_irq_enable_bit = pwdata[`MIE_CTRL_IRQEN_BIT];
            end
            if (paddr == `MIE_ADDR_IRQ_MASK) begin
               s_nxt.irq_mask = pwdata[3:0];
            end
         end else if (paddr == `MIE_ADDR_IRQ_STAT) begin
            // Clear only what the read reported, so an event taken at the setup edge stays pending
            s_nxt.irq_stat = s_r.irq_stat & ~s_r.prdata[3:0];
         end
      end

      // Sticky events, set after clear so a coincident event survives
      s_nxt.irq_stat = s_nxt.irq_stat | ev;
      s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_mask);
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '{wake_s1: 1'b0, wake_s2: 1'b0, pwr: MIE_PWR_RUN,
                  converter_control_reg: `MIE_RST_CTRL, irq_mask: `MIE_RST_MASK,
                  default: '0};
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs straight from the state register
   assign prdata = s_r.prdata;
   assign pready = s_r.pready;
   assign pslverr = s_r.pslverr;
   assign skip_next = s_r.skip;
   assign acc_out = s_r.acc;
   assign acc_we = s_r.acc_we;
   assign pwr_state = s_r.pwr;
   assign watchdog_stop_enable = s_r.watchdog_stop_enable;
   assign watchdog_flag_one = s_r.watchdog_flag_one;
   assign conversion_done_flag = s_r.conversion_done_flag;
   assign adc_start = s_r.adc_start;
   assign cmp_start = s_r.cmp_start;
   assign irq = s_r.irq;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   a_power_off_armed: assert property (@(posedge pclk) disable iff (!presetn)
      exec_ok && op == MIE_OP_POWER_OFF && s_r.pwr == MIE_PWR_ARMED |=> s_r.pwr == MIE_PWR_BACKUP)
      else $error("armed power-off did not enter backup");

   a_power_off_unarmed: assert property (@(posedge pclk) disable iff (!presetn)
      exec_ok && op == MIE_OP_POWER_OFF && s_r.pwr == MIE_PWR_RUN |=> s_r.pwr == MIE_PWR_RUN)
      else $error("unarmed power-off changed power state");

   a_wd_stop_enable: assert property (@(posedge pclk) disable iff (!presetn)
      exec_ok && op == MIE_OP_WD_STOP |=> s_r.watchdog_stop_enable ##1 s_r.watchdog_stop_enable)
      else $error("watchdog stop enable not held");

   a_wd_test_skip: assert property (@(posedge pclk) disable iff (!presetn)
      exec_ok && op == MIE_OP_WD_TEST && s_r.watchdog_flag_one && !watchdog_flag_set
      |=> s_r.skip && !s_r.watchdog_flag_one)
      else $error("watchdog test did not skip and clear");

   a_addi_no_overflow: assert property (@(posedge pclk) disable iff (!presetn)
      exec_ok && op == MIE_OP_ADDI && !addi_sum[4]
      |=> s_r.skip && s_r.acc_we && s_r.acc == $past(acc_in) + $past(imm))
      else $error("add-immediate without overflow wrong");

   a_addi_overflow: assert property (@(posedge pclk) disable iff (!presetn)
      exec_ok && op == MIE_OP_ADDI && addi_sum[4] |=> !s_r.skip && s_r.acc_we)
      else $error("add-immediate overflow skipped");

   a_conv_start_adc: assert property (@(posedge pclk) disable iff (!presetn)
      exec_ok && op == MIE_OP_CONV_START && !s_r.converter_control_reg[`MIE_CTRL_MODE_BIT] && !conversion_done_set
      |=> s_r.adc_start && !s_r.cmp_start && !s_r.conversion_done_flag)
      else $error("conversion start wrong in conversion mode");

   a_conv_start_cmp: assert property (@(posedge pclk) disable iff (!presetn)
      exec_ok && op == MIE_OP_CONV_START && s_r.converter_control_reg[`MIE_CTRL_MODE_BIT]
      |=> s_r.cmp_start && !s_r.adc_start)
      else $error("comparator start wrong in comparator mode");

   a_done_skip_hit: assert property (@(posedge pclk) disable iff (!presetn)
      exec_ok && op == MIE_OP_CONV_SKIP && !s_r.converter_irq_enable_bit &&
      s_r.conversion_done_flag && !conversion_done_set |=> s_r.skip && !s_r.conversion_done_flag)
      else $error("done-skip did not skip and clear");

   a_done_skip_nop: assert property (@(posedge pclk) disable iff (!presetn)
      exec_ok && op == MIE_OP_CONV_SKIP && s_r.converter_irq_enable_bit
      |=> !s_r.skip && s_r.conversion_done_flag == $past(s_r.conversion_done_flag || conversion_done_set))
      else $error("done-skip acted with irq enable set");

endmodule
`default_nettype wire

// ---- core/mie_op_decode.sv ----
// Instruction word decoder of the execute block
`timescale 1ns/10ps
`default_nettype none
`include "mie_defines.svh"

module mie_op_decode #(
   parameter logic [9:0] OP_POWER_OFF = `MIE_OP_POWER_OFF,
   parameter logic [9:0] OP_POWER_EN = `MIE_OP_POWER_EN,
   parameter logic [9:0] OP_WD_STOP = `MIE_OP_WD_STOP,
   parameter logic [9:0] OP_WD_TEST = `MIE_OP_WD_TEST,
   parameter logic [9:0] OP_CONV_START = `MIE_OP_CONV_START,
   parameter logic [9:0] OP_CONV_SKIP = `MIE_OP_CONV_SKIP
) (
   // Instruction word
   input wire logic [9:0] instr_code,
   // Decoded class and immediate
   output mie_pkg::mie_op_t op,
   output logic [3:0] imm
);
   import mie_pkg::*;

   // Map one instruction word onto its class
   function automatic mie_op_t classify(input logic [9:0] code);
      mie_op_t k;
      k = MIE_OP_NONE;
      if (code[9:4] == `MIE_OP_ADDI_HI) begin
         k = MIE_OP_ADDI;
      end else if (code == OP_POWER_OFF) begin
         k = MIE_OP_POWER_OFF;
      end else if (code == OP_POWER_EN) begin
         k = MIE_OP_POWER_EN;
      end else if (code == OP_WD_STOP) begin
         k = MIE_OP_WD_STOP;
      end else if (code == OP_WD_TEST) begin
         k = MIE_OP_WD_TEST;
      end else if (code == OP_CONV_START) begin
         k = MIE_OP_CONV_START;
      end else if (code == OP_CONV_SKIP) begin
         k = MIE_OP_CONV_SKIP;
      end
      return k;
   endfunction

   // Class and low nibble
   assign op = classify(instr_code);
   assign imm = instr_code[3:0];

endmodule
`default_nettype wire

// ---- core/mie_pkg.sv ----
// Types of the miscellaneous instruction execute block
`default_nettype none
package mie_pkg;

   // Power state, one-hot
   typedef enum logic [2:0] {
      MIE_PWR_RUN = 3'b001,
      MIE_PWR_ARMED = 3'b010,
      MIE_PWR_BACKUP = 3'b100
   } mie_pwr_t;

   // Decoded instruction class
   typedef enum logic [2:0] {
      MIE_OP_NONE, MIE_OP_ADDI, MIE_OP_POWER_OFF, MIE_OP_POWER_EN,
      MIE_OP_WD_STOP, MIE_OP_WD_TEST, MIE_OP_CONV_START, MIE_OP_CONV_SKIP
   } mie_op_t;

   // Whole state of the execute block
   typedef struct packed {
      logic wake_s1;
      logic wake_s2;
      mie_pwr_t pwr;
      logic [3:0] converter_control_reg;
      logic converter_irq_enable_bit;
      logic watchdog_stop_enable;
      logic watchdog_flag_one;
      logic conversion_done_flag;
      logic skip;
      logic [3:0] acc;
      logic acc_we;
      logic adc_start;
      logic cmp_start;
      logic [3:0] irq_stat;
      logic [3:0] irq_mask;
      logic irq;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } mie_state_t;

endpackage
`default_nettype wire
